// ### ee_timer.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants for the serial memory slave
package ee_pkg;
   // memory geometry
   localparam int EE_ADDR_W = 11;            // 2048 bytes
   localparam int EE_OFS_W = 5;              // byte offset inside a page
   localparam int EE_PAGE_BYTES = 32;        // bytes per page buffer
   localparam int EE_BLK_W = 3;              // block select bits
   // slave address byte layout
   localparam int EE_DIR_BIT = 0;            // 1 = read, 0 = write
   localparam int EE_BLK_LSB = 1;            // block select field low bit
   localparam int EE_TYPE_LSB = 4;           // device type field low bit
   localparam int EE_TYPE_W = 4;             // device type field width
   localparam logic [2:0] EE_LAST_BIT = 3'h7; // bit count of a byte's last bit
   localparam logic [4:0] EE_LAST_OFS = 5'h1F; // last byte of a page
   // self-timed erase/write cycle
   localparam int EE_TWR_MS = 10;            // longest erase/write time, ms
   localparam int EE_REF_HZ = 10_000_000;    // reference clock rate
   localparam int EE_TWR_CYC = EE_TWR_MS * (EE_REF_HZ / 1000); // rounded down
endpackage : ee_pkg

////////////////////////////////////////////////////////////////////////////////
// erase/write cycle timer, reference clock domain
module ee_wr_timer
   import ee_pkg::*;
#(
   parameter int P_CYCLES = EE_TWR_CYC       // length of one erase/write cycle
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_start,                 // one-cycle start pulse
   // status
   output logic o_busy                       // high while the cycle runs
);
   localparam int CW = $clog2(P_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

   logic [CW-1:0] cnt_ff;                    // elapsed cycles
   logic busy_ff;                            // cycle in progress

   // count out the programming time; a start while busy is ignored
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end
      else if (i_start && !busy_ff)
      begin
         cnt_ff <= '0;
         busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
         if (cnt_ff == LAST)
         begin
            busy_ff <= 1'b0;
         end
         else
         begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   assign o_busy = busy_ff;
endmodule : ee_wr_timer

// ### ee_i2c_eeprom.sv
// Summary of operation
// R1: bus idle only while both lines high
// R2: data fall with clock high starts transfer
// R3: data rise with clock high stops transfer
// R4: data change during clock high is control
// R5: one data bit per clock high period
// R6: eight bits then receiver acknowledge bit
// R7: acknowledger holds data low through clock high
// R8: master nack ends read, device releases line
// R9: first byte: type field, three block bits
// R10: address byte lsb one reads, zero writes
// R11: write: word address byte, then data bytes
// R12: write at most 32 bytes, read unlimited
// R13: stop after write starts timed 10 ms cycle
// R14: busy programming: no ack, bus ignored
// R15: page write accepts 32 bytes, each acknowledged
// R16: write increments low five bits, page fixed
// R17: master sends at most 32 bytes per write
// R18: protect pin high: data nacked, memory kept
// R19: protected writes still ack address bytes
// R20: current, random and sequential reads supported
// R21: read increments full address, 2047 wraps 0
// R22: works at low, standard and fast rates
// R23: every byte travels most significant bit first
// R24: random read uses dummy write then restart
// R25: foreign type field: no ack until start
module ee_i2c_eeprom
   import ee_pkg::*;
#(
   parameter int P_WR_CYCLES = EE_TWR_CYC,   // erase/write time in reference cycles
   parameter logic [EE_TYPE_W-1:0] P_DEV_TYPE = 4'h5 // arbitrary value
)
(
   // clocks and reset
   input wire logic I_REF_CLK,               // reference clock, write timer
   input wire logic I_RST_N,                 // asynchronous reset, active low
   input wire logic I_LINK_CLK,              // bus sampling clock
   // serial bus, open drain data
   input wire logic I_SCL,                   // serial clock pin
   input wire logic I_SDA,                   // serial data pin level
   output logic O_SDA_O,                     // data drive value, always low
   output logic O_SDA_OE,                    // high while pulling data low
   // control
   input wire logic I_WP,                    // write protect, high protects
   // status
   output logic O_BUSY                       // erase/write cycle running
);
   typedef enum {
      ST_IDLE,                               // waiting for a start
      ST_DEV,                                // receiving slave address
      ST_WORD,                               // receiving word address
      ST_WDATA,                              // receiving write data
      ST_ACK,                                // acknowledge slot after a byte
      ST_RDATA,                              // sending a read byte
      ST_RACK                                // master acknowledge slot
   } ee_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // link domain declarations
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;     // clock pin synchroniser and delay
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;     // data pin synchroniser and delay
   logic wp_s1_ff, wp_s2_ff;                 // write protect synchroniser
   logic bz_s1_ff, bz_s2_ff;                 // busy level back from timer
   ee_state_e state_ff;                      // protocol state
   ee_state_e after_ff;                      // state to enter after ack slot
   logic [2:0] cnt_ff;                       // bit counter
   logic [7:0] sh_ff;                        // receive shift register
   logic got_ff;                             // full byte received
   logic [7:0] tx_ff;                        // transmit shift register
   logic mack_ff;                            // master acknowledged last byte
   logic sda_oe_ff;                          // pull data low
   logic sda_o_ff;                           // drive value of the pin
   logic [EE_ADDR_W-1:0] addr_ff;            // internal address pointer
   logic [EE_PAGE_BYTES-1:0] mask_ff;        // page bytes holding new data
   logic dirty_ff;                           // page buffer awaits commit
   logic tog_ff;                             // commit request toggle
   logic pend_ff;                            // write cycle pending, bus ignored
   logic seen_ff;                            // timer busy seen since commit
   logic cp_run_ff;                          // copying page into array
   logic [EE_OFS_W-1:0] cp_idx_ff;           // copy position in page
   logic [7:0] page_mem [EE_PAGE_BYTES];     // page buffer
   logic [7:0] mem [2**EE_ADDR_W];           // memory array

   // ref domain declarations
   logic tg_s1_ff, tg_s2_ff, tg_s3_ff;       // commit toggle synchroniser
   logic tmr_busy;                           // timer running

   // decoded bus events
   logic scl_rise, scl_fall, start_c, stop_c;
   logic rx_state, byte_ev, dev_hit, data_take, rd_load, commit_ev;
   logic [7:0] mem_q;                        // byte at the address pointer

   ////////////////////////////////////////////////////////////////////////////
   // two flip-flops on every pin, then one delay stage on clock and data for edge finding
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         wp_s1_ff <= 1'b0;
         wp_s2_ff <= 1'b0;
         bz_s1_ff <= 1'b0;
         bz_s2_ff <= 1'b0;
      end
      else
      begin
         scl_s1_ff <= I_SCL;
         scl_s2_ff <= scl_s1_ff;
         scl_d_ff <= scl_s2_ff;
         sda_s1_ff <= I_SDA;
         sda_s2_ff <= sda_s1_ff;
         sda_d_ff <= sda_s2_ff;
         wp_s1_ff <= I_WP;
         wp_s2_ff <= wp_s1_ff;
         bz_s1_ff <= tmr_busy;
         bz_s2_ff <= bz_s1_ff;
      end
   end

   // edge detection looks only at the second stage and the delay stage;
   // oversampling needs no bit timing, so any bus rate up to fast works (R22)
   assign scl_rise = scl_s2_ff && !scl_d_ff;
   assign scl_fall = !scl_s2_ff && scl_d_ff;
   assign start_c = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff; // R2 R4
   assign stop_c = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;  // R3 R4

   // byte level decisions
   assign rx_state = (state_ff == ST_DEV) || (state_ff == ST_WORD) || (state_ff == ST_WDATA);
   assign byte_ev = scl_fall && got_ff && rx_state && !pend_ff;
   assign dev_hit = (sh_ff[EE_TYPE_LSB +: EE_TYPE_W] == P_DEV_TYPE); // R9 R25
   assign data_take = byte_ev && (state_ff == ST_WDATA) && !wp_s2_ff; // R18
   assign rd_load = scl_fall && !pend_ff
      && (((state_ff == ST_ACK) && (after_ff == ST_RDATA))
      || ((state_ff == ST_RACK) && mack_ff));
   assign commit_ev = stop_c && !pend_ff && dirty_ff; // R13
   assign mem_q = mem[addr_ff];

   ////////////////////////////////////////////////////////////////////////////
   // protocol engine: bits, bytes, acknowledge and read shifting
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         state_ff <= ST_IDLE;
         after_ff <= ST_IDLE;
         cnt_ff <= '0;
         sh_ff <= '0;
         got_ff <= 1'b0;
         tx_ff <= '0;
         mack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end
      else if (pend_ff)
      begin
         // programming: release the line and ignore everything (R14)
         state_ff <= ST_IDLE;
         got_ff <= 1'b0;
         cnt_ff <= '0;
         sda_oe_ff <= 1'b0; // R14
      end
      else if (start_c)
      begin
         // start or repeated start: expect a slave address (R1 R2 R24)
         state_ff <= ST_DEV;
         cnt_ff <= '0;
         got_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end
      else if (stop_c)
      begin
         state_ff <= ST_IDLE; // R3
         got_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_IDLE:
            begin
               // foreign traffic or finished read: wait for next start (R25)
               sda_oe_ff <= 1'b0;
            end
            ST_DEV, ST_WORD, ST_WDATA:
            begin
               if (scl_rise)
               begin
                  // sample while the clock is high, msb arrives first (R5 R23)
                  sh_ff <= {sh_ff[6:0], sda_s2_ff};
                  cnt_ff <= cnt_ff + 3'h1;
                  got_ff <= (cnt_ff == EE_LAST_BIT); // R6
               end
               else if (byte_ev)
               begin
                  got_ff <= 1'b0;
                  cnt_ff <= '0;
                  if (state_ff == ST_DEV)
                  begin
                     if (dev_hit)
                     begin
                        state_ff <= ST_ACK;
                        sda_oe_ff <= 1'b1; // R7 R19
                        // direction bit picks the next phase (R10)
                        after_ff <= sh_ff[EE_DIR_BIT] ? ST_RDATA : ST_WORD; // R10
                     end
                     else
                     begin
                        state_ff <= ST_IDLE; // R25
                     end
                  end
                  else if (state_ff == ST_WORD)
                  begin
                     state_ff <= ST_ACK;
                     sda_oe_ff <= 1'b1; // R11 R19
                     after_ff <= ST_WDATA;
                  end
                  else
                  begin
                     // data byte: acknowledged only when not protected
                     state_ff <= ST_ACK;
                     sda_oe_ff <= !wp_s2_ff; // R15 R18
                     after_ff <= ST_WDATA;
                  end
               end
            end
            ST_ACK:
            begin
               // ack held low across the whole high phase; on the fall freed, or set to the first read bit
               if (rd_load)
               begin
                  tx_ff <= mem_q;
                  sda_oe_ff <= !mem_q[7]; // R23
                  cnt_ff <= '0;
                  state_ff <= ST_RDATA;
               end
               else if (scl_fall)
               begin
                  sda_oe_ff <= 1'b0; // R7
                  state_ff <= after_ff;
               end
            end
            ST_RDATA:
            begin
               // change data only while the clock is low (R4)
               if (scl_fall)
               begin
                  if (cnt_ff == EE_LAST_BIT)
                  begin
                     sda_oe_ff <= 1'b0; // R6
                     state_ff <= ST_RACK;
                  end
                  else
                  begin
                     cnt_ff <= cnt_ff + 3'h1;
                     sda_oe_ff <= !tx_ff[6];
                     tx_ff <= {tx_ff[6:0], 1'b0};
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
               begin
                  mack_ff <= !sda_s2_ff;
               end
               else if (rd_load)
               begin
                  // master asked for more: sequential read, no limit (R12 R20)
                  tx_ff <= mem_q;
                  sda_oe_ff <= !mem_q[7];
                  cnt_ff <= '0;
                  state_ff <= ST_RDATA;
               end
               else if (scl_fall)
               begin
                  // no ack: leave the line high so the master can stop (R8)
                  sda_oe_ff <= 1'b0; // R8
                  state_ff <= ST_IDLE;
               end
            end
            default:
            begin
               state_ff <= ST_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address pointer and page byte mask
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         addr_ff <= '0;
         mask_ff <= '0;
      end
      else if (byte_ev && (state_ff == ST_DEV) && dev_hit)
      begin
         // block select forms the top address bits (R9)
         addr_ff[EE_ADDR_W-1 -: EE_BLK_W] <= sh_ff[EE_BLK_LSB +: EE_BLK_W]; // R9
         if (!sh_ff[EE_DIR_BIT])
         begin
            mask_ff <= '0;
         end
      end
      else if (byte_ev && (state_ff == ST_WORD))
      begin
         addr_ff[7:0] <= sh_ff; // R11
      end
      else if (data_take)
      begin
         // page number stays, offset wraps 31 to 0; beyond 32 bytes the
         // older bytes of the page are simply replaced (R17)
         mask_ff[addr_ff[EE_OFS_W-1:0]] <= 1'b1;
         addr_ff[EE_OFS_W-1:0] <= addr_ff[EE_OFS_W-1:0] + 5'h01; // R16
      end
      else if (rd_load)
      begin
         addr_ff <= addr_ff + 11'h001; // R21
      end
   end

   // page buffer keeps write data until the stop; no reset needed
   always_ff @(posedge I_LINK_CLK)
   begin
      if (data_take)
      begin
         page_mem[addr_ff[EE_OFS_W-1:0]] <= sh_ff; // R15
      end
   end

   // array update, one byte per cycle while the bus is locked out
   always_ff @(posedge I_LINK_CLK)
   begin
      if (cp_run_ff && mask_ff[cp_idx_ff])
      begin
         mem[{addr_ff[EE_ADDR_W-1:EE_OFS_W], cp_idx_ff}] <= page_mem[cp_idx_ff]; // R13 R16
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // commit: hand the write cycle to the timer and hold the bus off
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         dirty_ff <= 1'b0;
         tog_ff <= 1'b0;
         pend_ff <= 1'b0;
         seen_ff <= 1'b0;
         cp_run_ff <= 1'b0;
         cp_idx_ff <= '0;
      end
      else if (commit_ev)
      begin
         // protected or empty writes never get here, memory stays (R18)
         dirty_ff <= 1'b0;
         tog_ff <= !tog_ff; // R13
         pend_ff <= 1'b1; // R14
         seen_ff <= 1'b0;
         cp_run_ff <= 1'b1;
         cp_idx_ff <= '0;
      end
      else
      begin
         if (data_take)
         begin
            dirty_ff <= 1'b1;
         end
         if (cp_run_ff)
         begin
            cp_idx_ff <= cp_idx_ff + 5'h01;
            cp_run_ff <= (cp_idx_ff != EE_LAST_OFS);
         end
         if (bz_s2_ff)
         begin
            seen_ff <= 1'b1;
         end
         // stay locked until the timer has run and the copy is done;
         // a very short timer still cannot free the bus mid copy
         if (pend_ff && seen_ff && !bz_s2_ff && !cp_run_ff)
         begin
            pend_ff <= 1'b0; // R14
         end
      end
   end

   // open drain: the drive value is a constant low, only the enable moves
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         sda_o_ff <= 1'b0;
      end
      else
      begin
         sda_o_ff <= 1'b0;
      end
   end

   assign O_SDA_O = sda_o_ff;
   assign O_SDA_OE = sda_oe_ff;

   ////////////////////////////////////////////////////////////////////////////
   // reference domain: toggle crossing turns the commit into a start pulse
   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         tg_s1_ff <= 1'b0;
         tg_s2_ff <= 1'b0;
         tg_s3_ff <= 1'b0;
      end
      else
      begin
         tg_s1_ff <= tog_ff;
         tg_s2_ff <= tg_s1_ff;
         tg_s3_ff <= tg_s2_ff;
      end
   end

   // self-timed erase/write cycle
   ee_wr_timer #(
      .P_CYCLES(P_WR_CYCLES)
   ) u_timer (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_start(tg_s2_ff ^ tg_s3_ff), // R13
      .o_busy(tmr_busy)
   );

   assign O_BUSY = tmr_busy;
endmodule : ee_i2c_eeprom

// ### ee_i2c_eeprom_sva.sv
////////////////////////////////////////////////////////////////////////////////
// pin level checker for the serial memory slave
module ee_i2c_eeprom_sva
#(
   parameter int P_WR_CYCLES = 20 // erase/write length in ref clocks
)
(
   // clocks and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_LINK_CLK,
   // bus and control
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic O_SDA_O,
   input wire logic O_SDA_OE,
   input wire logic I_WP,
   input wire logic O_BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_d_ff; // scl one link clock ago
   logic [3:0] fall_cnt_ff; // link clocks since scl fell, saturating
   logic [4:0] idle_cnt_ff; // link clocks of an idle bus, saturating
   logic [31:0] busy_cnt_ff; // ref clocks of the current busy spell
   // pin history; a long idle spell only happens outside frames
   always_ff @(posedge I_LINK_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         scl_d_ff <= 1'b1;
         fall_cnt_ff <= 4'hF;
         idle_cnt_ff <= 5'h00;
      end
      else
      begin
         scl_d_ff <= I_SCL;
         if (scl_d_ff && !I_SCL)
            fall_cnt_ff <= 4'h0;
         else if (fall_cnt_ff != 4'hF)
            fall_cnt_ff <= fall_cnt_ff + 4'h1;
         if (!(I_SCL && I_SDA))
            idle_cnt_ff <= 5'h00;
         else if (idle_cnt_ff != 5'h1F)
            idle_cnt_ff <= idle_cnt_ff + 5'h01;
      end
   end
   // busy length, too long to unroll as a repetition
   always_ff @(posedge I_REF_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
         busy_cnt_ff <= 32'h0;
      else if (O_BUSY)
         busy_cnt_ff <= busy_cnt_ff + 32'h1;
      else
         busy_cnt_ff <= 32'h0;
   end
   sda_low_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      O_SDA_OE |-> !O_SDA_O) else $error("data driven high");
   oe_edge_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      $changed(O_SDA_OE) |-> !I_SCL) else $error("data moved with clock high");
   oe_timing_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      $changed(O_SDA_OE) |-> fall_cnt_ff inside {[4'h1:4'h8]}) else $error("late data");
   ack_hold_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      I_SCL && O_SDA_OE |=> O_SDA_OE || !I_SCL) else $error("low dropped early");
   idle_free_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      idle_cnt_ff >= 5'h10 |-> !O_SDA_OE) else $error("idle bus pulled low");
   busy_quiet_a: assert property (@(posedge I_LINK_CLK) disable iff (!I_RST_N)
      O_BUSY |-> !O_SDA_OE) else $error("answer while busy");
   busy_min_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(O_BUSY) |-> O_BUSY [*8]) else $error("busy too short");
   busy_max_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      busy_cnt_ff <= P_WR_CYCLES) else $error("busy too long");
   busy_idle_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(O_BUSY) |-> I_SCL && I_SDA) else $error("busy inside a frame");
   cover property (@(posedge I_LINK_CLK) disable iff (!I_RST_N) $rose(O_SDA_OE));
   cover property (@(posedge I_LINK_CLK) disable iff (!I_RST_N) I_SCL && O_SDA_OE);
   cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) $fell(O_BUSY));
endmodule : ee_i2c_eeprom_sva

bind ee_i2c_eeprom ee_i2c_eeprom_sva #(.P_WR_CYCLES(P_WR_CYCLES)) chk_u
(
   .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_LINK_CLK(I_LINK_CLK),
   .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_O(O_SDA_O), .O_SDA_OE(O_SDA_OE),
   .I_WP(I_WP), .O_BUSY(O_BUSY)
);

// ### ee_mst_model.sv
////////////////////////////////////////////////////////////////////////////////
// two-wire bus master; each call starts and ends on a rising clock edge
module ee_mst_model
(
   // clock
   input wire logic i_clk,
   // bus
   input wire logic i_sda, // resolved data wire
   output logic o_scl,
   output logic o_sda // 1 releases the wire to its pull-up
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus until the first frame
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // set both lines, then hold them two clocks
   task automatic step(input logic c, input logic d);
      o_scl <= c;
      o_sda <= d;
      repeat (2) @(posedge i_clk);
   endtask : step
   // one bit; data only moves while the clock is low
   task automatic pulse(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = i_sda;
      step(1'b0, b);
   endtask : pulse
   // start from idle, or repeated start inside a frame
   task automatic start();
      step(o_scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : start
   // stop leaves the bus idle
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop
   // byte out msb first, then the slave's acknowledge
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         pulse(b[i], r);
      pulse(1'b1, r);
      ack = !r;
   endtask : put
   // byte in; the last one is left unacknowledged
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         pulse(1'b1, d[i]);
      pulse(last, r);
   endtask : get
endmodule : ee_mst_model

// ### ee_i2c_eeprom_tb.sv
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the serial memory slave
module ee_i2c_eeprom_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P_CYC = 200; // short cycle that still outlasts one probe frame
   localparam logic [3:0] P_TYPE = 4'h5; // arbitrary value
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic scl, sda_m, sda_o, sda_oe, busy;
   logic [7:0] wdat [0:3]; // data of the next write
   int n_mismatch = 0;
   int total_checks = 0;
   // open drain data wire with its pull-up
   wire sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
   // 32 ns rising edges never meet the 100 ns rising edges
   always #50 ref_clk = ~ref_clk;
   always #16 link_clk = ~link_clk;
   ee_i2c_eeprom #(.P_WR_CYCLES(P_CYC), .P_DEV_TYPE(P_TYPE)) dut_u
   (
      .I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_LINK_CLK(link_clk),
      .I_SCL(scl), .I_SDA(sda_w), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe),
      .I_WP(wp), .O_BUSY(busy)
   );
   ee_mst_model mst_u (.i_clk(ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   // bounded wait; sampled on the falling edge, away from updates
   task automatic wait_busy(input logic lvl, input int lim);
      int t = 0;
      while (busy !== lvl && t < lim)
      begin
         @(negedge ref_clk);
         t++;
      end
      check("busy", lvl, busy);
      @(posedge ref_clk);
   endtask : wait_busy
   // slave address and word address of a write
   task automatic addr_w(input logic [10:0] a);
      logic ack;
      mst_u.start();
      mst_u.put({P_TYPE, a[10:8], 1'b0}, ack);
      check("slave ack", 1'b1, ack);
      mst_u.put(a[7:0], ack);
      check("word ack", 1'b1, ack);
   endtask : addr_w
   // a probe during the cycle must go unanswered
   task automatic lockout();
      logic ack;
      wait_busy(1'b1, 20);
      mst_u.start();
      mst_u.put({P_TYPE, 4'h1}, ack);
      check("busy ack", 1'b0, ack);
      mst_u.stop();
      wait_busy(1'b0, 400);
      repeat (4) @(posedge ref_clk);
   endtask : lockout
   task automatic wr(input logic [10:0] a, input int n, input logic prot);
      logic ack;
      wp <= prot;
      addr_w(a);
      for (int i = 0; i < n; i++)
      begin
         mst_u.put(wdat[i], ack);
         check("data ack", !prot, ack);
      end
      mst_u.stop();
      if (!prot)
         lockout();
   endtask : wr
   // dummy write then repeated start for reading
   task automatic rd_open(input logic [10:0] a);
      logic ack;
      addr_w(a);
      mst_u.start();
      mst_u.put({P_TYPE, a[10:8], 1'b1}, ack);
      check("read ack", 1'b1, ack);
   endtask : rd_open
   task automatic rd(input logic [7:0] exp, input logic last);
      logic [7:0] d;
      mst_u.get(last, d);
      check("read data", exp, d);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_foreign();
      logic ack;
      mst_u.start();
      mst_u.put({~P_TYPE, 4'h1}, ack);
      check("foreign ack", 1'b0, ack);
      mst_u.put({P_TYPE, 4'h1}, ack);
      check("stray ack", 1'b0, ack);
      mst_u.stop();
      $display("test foreign done");
   endtask : t_foreign
   // third byte wraps to the start of the last page
   task automatic t_page();
      wdat[0] = 8'h11;
      wdat[1] = 8'h22;
      wdat[2] = 8'h33;
      wr(11'h7FE, 3, 1'b0);
      wdat[0] = 8'h44;
      wr(11'h000, 1, 1'b0);
      $display("test page done");
   endtask : t_page
   task automatic t_read();
      logic ack;
      rd_open(11'h7FE);
      rd(8'h11, 1'b0);
      rd(8'h22, 1'b1);
      mst_u.stop();
      mst_u.start();
      mst_u.put({P_TYPE, 4'h1}, ack);
      check("current ack", 1'b1, ack);
      rd(8'h44, 1'b1);
      mst_u.stop();
      rd_open(11'h7E0);
      rd(8'h33, 1'b1);
      mst_u.stop();
      $display("test read done");
   endtask : t_read
   task automatic t_protect();
      wdat[0] = 8'h99;
      wr(11'h000, 1, 1'b1);
      wp <= 1'b0;
      repeat (20) @(negedge ref_clk);
      check("busy protect", 1'b0, busy);
      @(posedge ref_clk);
      rd_open(11'h000);
      rd(8'h44, 1'b1);
      mst_u.stop();
      $display("test protect done");
   endtask : t_protect
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_foreign();
      t_page();
      t_read();
      t_protect();
      summarize();
   end
   // the tests need some 2100 clocks; over nine times that means a hang
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      summarize();
   end
endmodule : ee_i2c_eeprom_tb
